// ==== omdet_defines.svh ====
// Overview of operation
// - Five-bit hysteresis field, default 10100.
// - Larger hysteresis widens band between rotation states.
// - Report face-up, face-down and four rotation states.
// - Rotation needs one axis high, other near zero.
// - Flat device classified by vertical axis sign.
// - Rotation changes only above incline threshold.
// - Incline threshold compared at 32 counts per g.
// - Candidate orientation must persist for timer count.
// - Any axis above wake threshold means active.
// - Unlatched mode also reports return to inactive.
// - Wake threshold read at 16 counts per g.
// - Motion state changes qualified by 8-bit counter.
`ifndef OMDET_DEFINES_SVH
`define OMDET_DEFINES_SVH

// Register byte addresses.
`define OMDET_ADDR_STATUS      8'h16
`define OMDET_ADDR_MOTION_CLR  8'h1A
`define OMDET_ADDR_CTRL1       8'h1B
`define OMDET_ADDR_WAKE_THR    8'h5A
`define OMDET_ADDR_TILT_ANGLE  8'h5C
`define OMDET_ADDR_HYST        8'h5F
`define OMDET_ADDR_TILT_TIMER  8'h60
`define OMDET_ADDR_WAKE_TIMER  8'h61

// Reset values.
`define OMDET_RST_CTRL1        8'h00
`define OMDET_RST_WAKE_THR     8'h08
`define OMDET_RST_TILT_ANGLE   8'h0C
`define OMDET_RST_HYST         8'h14
`define OMDET_RST_TILT_TIMER   8'h00
`define OMDET_RST_WAKE_TIMER   8'h00

// Field positions.
`define OMDET_CTRL1_ENABLE     7
`define OMDET_CTRL1_LATCH      4
`define OMDET_HYST_MSB         4
`define OMDET_STAT_MOTION      3
`define OMDET_CLR_MOTION       0

// Hysteresis to threshold mapping in counts at 32 counts per g.
`define OMDET_HI_BASE          7'h08
`define OMDET_LO_BASE          7'h24

`endif

// ==== omdet_pkg.sv ====
package omdet_pkg;

    // Reported orientation states.
    typedef enum logic [2:0] {
        OMDET_FACE_UP,
        OMDET_FACE_DOWN,
        OMDET_X_POS,
        OMDET_X_NEG,
        OMDET_Y_POS,
        OMDET_Y_NEG
    } omdet_orient_t;

endpackage : omdet_pkg

// ==== omdet_axis_cmp.sv ====
`timescale 1ns/1ps
`include "omdet_defines.svh"

// Classifies one in-plane axis sample against the high and low limits.
module omdet_axis_cmp #(
    parameter int W = 8
) (
    input  wire logic signed [W-1:0] sample,   // Axis acceleration, 32 counts per g.
    input  wire logic        [6:0]   hi_lim,   // Magnitude that marks a dominant axis.
    input  wire logic        [6:0]   lo_lim,   // Magnitude below which the axis is near zero.
    output logic                     is_pos,   // Axis is dominant and positive.
    output logic                     is_neg,   // Axis is dominant and negative.
    output logic                     is_mid    // Axis lies strictly inside the low band.
);

    logic signed [W+1:0] s_ext;  // Sign-extended sample.
    logic signed [W+1:0] hi_ext; // Signed high limit.
    logic signed [W+1:0] lo_ext; // Signed low limit.

    // Dominance needs the limit reached, the middle band is open at both ends.
    always_comb begin
        s_ext  = (W+2)'(sample);
        hi_ext = (W+2)'(signed'({1'b0, hi_lim}));
        lo_ext = (W+2)'(signed'({1'b0, lo_lim}));
        is_pos = s_ext >= hi_ext;
        is_neg = s_ext <= -hi_ext;
        is_mid = (s_ext < lo_ext) && (s_ext > -lo_ext);
    end

endmodule : omdet_axis_cmp

// ==== omdet_top.sv ====
`timescale 1ns/1ps
`include "omdet_defines.svh"

// Orientation and wake-on-motion detection, evaluated once per sample set.
module omdet_top #(
    parameter int W = 8
) (
    input  wire logic                clk,          // System clock.
    input  wire logic                nrst,         // Asynchronous reset, active low.
    input  wire logic                reg_wr,       // Register write strobe.
    input  wire logic                reg_rd,       // Register read strobe.
    input  wire logic        [7:0]   reg_addr,     // Register byte address.
    input  wire logic        [7:0]   reg_wdata,    // Register write data.
    output logic             [7:0]   reg_rdata,    // Registered read data.
    input  wire logic                sample_valid, // One pulse per sample set.
    input  wire logic signed [W-1:0] acc_x,        // X acceleration, 32 counts per g.
    input  wire logic signed [W-1:0] acc_y,        // Y acceleration, 32 counts per g.
    input  wire logic signed [W-1:0] acc_z,        // Z acceleration, 32 counts per g.
    input  wire logic signed [W-1:0] hp_x,         // High-pass X, 16 counts per g.
    input  wire logic signed [W-1:0] hp_y,         // High-pass Y, 16 counts per g.
    input  wire logic signed [W-1:0] hp_z,         // High-pass Z, 16 counts per g.
    output omdet_pkg::omdet_orient_t orient,       // Reported orientation state.
    output logic                     orient_change,// Pulse when a new state is reported.
    output logic                     motion_flag,  // Motion indication.
    output logic                     motion_start, // Pulse on qualified entry to active.
    output logic                     motion_end    // Pulse on return to inactive, unlatched.
);

    // Squared magnitude, used for both in-plane axes.
    function automatic logic [2*W-1:0] sq(input logic signed [W-1:0] v);
        logic signed [2*W-1:0] p;
        p  = (2*W)'(v) * (2*W)'(v);
        sq = p;
    endfunction : sq

    // Magnitude of a signed sample.
    function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
        mag = v[W-1] ? W'(-v) : W'(v);
    endfunction : mag

    // Software-visible registers.
    logic [7:0] ctrl1_r,      ctrl1_nxt;      // Enable and latch mode.
    logic [7:0] wake_thr_r,   wake_thr_nxt;   // Wake threshold.
    logic [7:0] tilt_ang_r,   tilt_ang_nxt;   // Incline threshold.
    logic [7:0] hyst_r,       hyst_nxt;       // Trim bits and hysteresis field.
    logic [7:0] tilt_tmr_r,   tilt_tmr_nxt;   // Orientation debounce count.
    logic [7:0] wake_tmr_r,   wake_tmr_nxt;   // Motion qualify count.
    logic [7:0] rdata_r,      rdata_nxt;      // Read data.

    // Detection state.
    omdet_pkg::omdet_orient_t cur_r, cur_nxt;   // Reported orientation.
    omdet_pkg::omdet_orient_t pend_r, pend_nxt; // Candidate being debounced.
    logic [7:0] ocnt_r,  ocnt_nxt;              // Orientation debounce counter.
    logic       ochg_r,  ochg_nxt;              // Orientation change pulse.
    logic       mact_r,  mact_nxt;              // Qualified motion state.
    logic [7:0] mcnt_r,  mcnt_nxt;              // Motion qualify counter.
    logic       mflag_r, mflag_nxt;             // Sticky motion flag.
    logic       mst_r,   mst_nxt;               // Motion start pulse.
    logic       mend_r,  mend_nxt;              // Motion end pulse.

    logic       enable;   // Detection running.
    logic       latched;  // Latched motion mode.
    logic       clr_mot;  // Host clears the latched motion flag.
    logic [6:0] hi_lim;   // Dominant axis limit.
    logic [6:0] lo_lim;   // Near-zero axis limit.
    logic       x_pos, x_neg, x_mid, y_pos, y_neg, y_mid;
    logic       tilted;   // Incline above threshold.
    logic       raw_act;  // Any high-pass axis above threshold.
    omdet_pkg::omdet_orient_t cand; // Candidate from this sample set.

    assign enable  = ctrl1_r[`OMDET_CTRL1_ENABLE];
    assign latched = ctrl1_r[`OMDET_CTRL1_LATCH];
    assign clr_mot = reg_wr && (reg_addr == `OMDET_ADDR_MOTION_CLR)
                     && reg_wdata[`OMDET_CLR_MOTION];

    // A larger hysteresis raises the dominant limit and lowers the near-zero limit.
    always_comb begin
        hi_lim = `OMDET_HI_BASE + {2'h0, hyst_r[`OMDET_HYST_MSB:0]};
        lo_lim = `OMDET_LO_BASE - {2'h0, hyst_r[`OMDET_HYST_MSB:0]};
    end

    omdet_axis_cmp #(.W(W)) u_cmp_x (
        .sample (acc_x),
        .hi_lim (hi_lim),
        .lo_lim (lo_lim),
        .is_pos (x_pos),
        .is_neg (x_neg),
        .is_mid (x_mid)
    );

    omdet_axis_cmp #(.W(W)) u_cmp_y (
        .sample (acc_y),
        .hi_lim (hi_lim),
        .lo_lim (lo_lim),
        .is_pos (y_pos),
        .is_neg (y_neg),
        .is_mid (y_mid)
    );

    // Register writes and read data; the host keeps the trim bits itself.
    always_comb begin
        ctrl1_nxt    = ctrl1_r;
        wake_thr_nxt = wake_thr_r;
        tilt_ang_nxt = tilt_ang_r;
        hyst_nxt     = hyst_r;
        tilt_tmr_nxt = tilt_tmr_r;
        wake_tmr_nxt = wake_tmr_r;
        rdata_nxt    = rdata_r;
        if (reg_wr) begin
            case (reg_addr)
                `OMDET_ADDR_CTRL1:      ctrl1_nxt    = reg_wdata;
                `OMDET_ADDR_WAKE_THR:   wake_thr_nxt = reg_wdata;
                `OMDET_ADDR_TILT_ANGLE: tilt_ang_nxt = reg_wdata;
                `OMDET_ADDR_HYST:       hyst_nxt     = reg_wdata;
                `OMDET_ADDR_TILT_TIMER: tilt_tmr_nxt = reg_wdata;
                `OMDET_ADDR_WAKE_TIMER: wake_tmr_nxt = reg_wdata;
                default:                ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `OMDET_ADDR_CTRL1:      rdata_nxt = ctrl1_r;
                `OMDET_ADDR_WAKE_THR:   rdata_nxt = wake_thr_r;
                `OMDET_ADDR_TILT_ANGLE: rdata_nxt = tilt_ang_r;
                `OMDET_ADDR_HYST:       rdata_nxt = hyst_r;
                `OMDET_ADDR_TILT_TIMER: rdata_nxt = tilt_tmr_r;
                `OMDET_ADDR_WAKE_TIMER: rdata_nxt = wake_tmr_r;
                `OMDET_ADDR_STATUS: begin
                    rdata_nxt = {4'h0, motion_flag, 3'(cur_r)};
                end
                default:                rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register storage.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl1_r    <= `OMDET_RST_CTRL1;
            wake_thr_r <= `OMDET_RST_WAKE_THR;
            tilt_ang_r <= `OMDET_RST_TILT_ANGLE;
            hyst_r     <= `OMDET_RST_HYST;
            tilt_tmr_r <= `OMDET_RST_TILT_TIMER;
            wake_tmr_r <= `OMDET_RST_WAKE_TIMER;
            rdata_r    <= 8'h00;
        end else begin
            ctrl1_r    <= ctrl1_nxt;
            wake_thr_r <= wake_thr_nxt;
            tilt_ang_r <= tilt_ang_nxt;
            hyst_r     <= hyst_nxt;
            tilt_tmr_r <= tilt_tmr_nxt;
            wake_tmr_r <= wake_tmr_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // Candidate orientation for the current sample set.
    always_comb begin
        tilted = ({1'b0, sq(acc_x)} + {1'b0, sq(acc_y)})
                 > {1'b0, (2*W)'(tilt_ang_r) * (2*W)'(tilt_ang_r)};
        cand = cur_r;
        if (!tilted) begin
            cand = acc_z[W-1] ? omdet_pkg::OMDET_FACE_DOWN
                              : omdet_pkg::OMDET_FACE_UP;
        end else if (x_pos && y_mid) begin
            cand = omdet_pkg::OMDET_X_POS;
        end else if (x_neg && y_mid) begin
            cand = omdet_pkg::OMDET_X_NEG;
        end else if (y_pos && x_mid) begin
            cand = omdet_pkg::OMDET_Y_POS;
        end else if (y_neg && x_mid) begin
            cand = omdet_pkg::OMDET_Y_NEG;
        end
        raw_act = (mag(hp_x) > wake_thr_r) || (mag(hp_y) > wake_thr_r)
                  || (mag(hp_z) > wake_thr_r);
    end

    // Debounce of orientation and qualification of motion state.
    always_comb begin
        cur_nxt   = cur_r;
        pend_nxt  = pend_r;
        ocnt_nxt  = ocnt_r;
        ochg_nxt  = 1'b0;
        mact_nxt  = mact_r;
        mcnt_nxt  = mcnt_r;
        mflag_nxt = mflag_r;
        mst_nxt   = 1'b0;
        mend_nxt  = 1'b0;
        if (clr_mot) begin
            mflag_nxt = 1'b0;
        end
        if (!enable) begin
            ocnt_nxt = 8'h00;
            mcnt_nxt = 8'h00;
        end else if (sample_valid) begin
            // A candidate must persist for the programmed number of sets.
            if (cand == cur_r) begin
                ocnt_nxt = 8'h00;
            end else if (cand != pend_r) begin
                pend_nxt = cand;
                ocnt_nxt = 8'h01;
                if (tilt_tmr_r <= 8'h01) begin
                    cur_nxt  = cand;
                    ochg_nxt = 1'b1;
                    ocnt_nxt = 8'h00;
                end
            end else if (ocnt_r + 8'h01 >= tilt_tmr_r) begin
                cur_nxt  = pend_r;
                ochg_nxt = 1'b1;
                ocnt_nxt = 8'h00;
            end else begin
                ocnt_nxt = ocnt_r + 8'h01;
            end
            // Motion state flips after the qualify count of differing samples.
            if (raw_act == mact_r) begin
                mcnt_nxt = 8'h00;
            end else if (mcnt_r + 8'h01 >= wake_tmr_r) begin
                mact_nxt = raw_act;
                mcnt_nxt = 8'h00;
                if (raw_act) begin
                    mst_nxt   = 1'b1;
                    mflag_nxt = 1'b1;
                end else begin
                    mend_nxt = !latched;
                end
            end else begin
                mcnt_nxt = mcnt_r + 8'h01;
            end
        end
    end

    // Detection state storage.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_r   <= omdet_pkg::OMDET_FACE_UP;
            pend_r  <= omdet_pkg::OMDET_FACE_UP;
            ocnt_r  <= 8'h00;
            ochg_r  <= 1'b0;
            mact_r  <= 1'b0;
            mcnt_r  <= 8'h00;
            mflag_r <= 1'b0;
            mst_r   <= 1'b0;
            mend_r  <= 1'b0;
        end else begin
            cur_r   <= cur_nxt;
            pend_r  <= pend_nxt;
            ocnt_r  <= ocnt_nxt;
            ochg_r  <= ochg_nxt;
            mact_r  <= mact_nxt;
            mcnt_r  <= mcnt_nxt;
            mflag_r <= mflag_nxt;
            mst_r   <= mst_nxt;
            mend_r  <= mend_nxt;
        end
    end

    // Latched mode shows the sticky flag, unlatched mode the live state.
    assign motion_flag   = latched ? mflag_r : mact_r;
    assign reg_rdata     = rdata_r;
    assign orient        = cur_r;
    assign orient_change = ochg_r;
    assign motion_start  = mst_r;
    assign motion_end    = mend_r;

endmodule : omdet_top

// ==== omdet_properties.sv ====
`timescale 1ns/1ps
`include "omdet_defines.svh"

// Temporal checks on the detector outputs, seen from the top-level ports only.
module omdet_chk (
    input wire logic                     clk,
    input wire logic                     nrst,
    input wire logic                     reg_wr,
    input wire logic               [7:0] reg_addr,
    input wire logic               [7:0] reg_wdata,
    input wire logic                     sample_valid,
    input wire omdet_pkg::omdet_orient_t orient,
    input wire logic                     orient_change,
    input wire logic                     motion_flag,
    input wire logic                     motion_start,
    input wire logic                     motion_end
);
    logic latch_r;   // Shadow of the latch-mode bit, taken from control writes.
    logic latch_nxt; // Next value of the shadow bit.

    // A control write replaces the shadow bit; nothing else touches it.
    always_comb begin
        latch_nxt = latch_r;
        if (reg_wr && reg_addr == `OMDET_ADDR_CTRL1) begin
            latch_nxt = reg_wdata[`OMDET_CTRL1_LATCH];
        end
    end

    // The shadow bit clears with the block so both start in unlatched mode.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // A sample set followed by a reported change of orientation.
    sequence s_moved;
        sample_valid ##1 orient_change;
    endsequence

    chk_change_cause:   assert property (orient_change |-> $past(sample_valid))
        else $error("orientation change without a sample set");
    chk_change_moves:   assert property (s_moved |-> orient != $past(orient))
        else $error("orientation change pulse with an unchanged state");
    chk_orient_holds:   assert property (!orient_change |-> $stable(orient))
        else $error("orientation moved without a change pulse");
    chk_start_cause:    assert property (motion_start |-> $past(sample_valid))
        else $error("motion start without a sample set");
    chk_end_cause:      assert property (motion_end |-> $past(sample_valid))
        else $error("motion end without a sample set");
    chk_start_flag:     assert property (motion_start |-> motion_flag)
        else $error("motion start without the motion indication");
    chk_start_single:   assert property (motion_start |=> !motion_start)
        else $error("motion start held for two cycles");
    chk_end_unflag:     assert property (motion_end |-> !motion_flag)
        else $error("motion end with the indication still set");
    chk_latched_no_end: assert property (latch_r && $past(latch_r) |-> !motion_end)
        else $error("motion end reported in latched mode");
endmodule : omdet_chk

bind omdet_top omdet_chk i_chk (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .sample_valid(sample_valid), .orient(orient),
    .orient_change(orient_change), .motion_flag(motion_flag), .motion_start(motion_start),
    .motion_end(motion_end));

// ==== omdet_host.sv ====
`timescale 1ns/1ps
`include "omdet_defines.svh"

// Host model: one register access per strobe, launched and dropped on falling edges.
module omdet_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // The bus starts idle.
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write or read; read data is valid when the task returns.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    = w;
        reg_rd    = !w;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = ~d;
    endtask : acc

    // Reconfigures the detectors with the enable bit cleared, then clears the sticky flag.
    task automatic cfg(input logic [4:0] h, input logic [7:0] tt, input logic [7:0] wt,
                       input logic [7:0] ctrl);
        logic [7:0] old;
        acc(1'b1, `OMDET_ADDR_CTRL1, 8'h00);
        acc(1'b0, `OMDET_ADDR_HYST, 8'h00);
        old = reg_rdata;
        acc(1'b1, `OMDET_ADDR_HYST, {old[7:5], h});
        acc(1'b1, `OMDET_ADDR_TILT_TIMER, tt);
        acc(1'b1, `OMDET_ADDR_WAKE_TIMER, wt);
        acc(1'b1, `OMDET_ADDR_CTRL1, ctrl);
        acc(1'b1, `OMDET_ADDR_MOTION_CLR, 8'h01);
    endtask : cfg
endmodule : omdet_host

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "omdet_defines.svh"

// Random sample sets checked against an integer model of both detectors.
module testbench;
    logic                     clk = 1'b0;
    logic                     nrst = 1'b0;
    logic                     sample_valid = 1'b0;
    logic signed        [7:0] ax = '0, ay = '0, az = '0, hx = '0, hy = '0, hz = '0;
    logic                     reg_wr, reg_rd;
    logic               [7:0] reg_addr, reg_wdata, reg_rdata;
    omdet_pkg::omdet_orient_t orient;
    logic                     orient_change, motion_flag, motion_start, motion_end;
    int                       failures = 0, num_checks = 0;
    int                       cur = 0, pend = 0, cnt = 0, act = 0, mcnt = 0, stk = 0;
    int                       lat = 0, h = 20, tt = 0, wt = 0, chg = 0, st = 0, en = 0;
    logic               [7:0] ra [7] = '{`OMDET_ADDR_HYST, `OMDET_ADDR_WAKE_THR,
        `OMDET_ADDR_TILT_ANGLE, `OMDET_ADDR_TILT_TIMER, `OMDET_ADDR_WAKE_TIMER,
        `OMDET_ADDR_CTRL1, 8'h20};
    logic               [7:0] rv [7] = '{`OMDET_RST_HYST, `OMDET_RST_WAKE_THR,
        `OMDET_RST_TILT_ANGLE, `OMDET_RST_TILT_TIMER, `OMDET_RST_WAKE_TIMER,
        `OMDET_RST_CTRL1, 8'h00};

    always #5 clk = ~clk;

    omdet_host i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    omdet_top i_dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .acc_x(ax), .acc_y(ay), .acc_z(az), .hp_x(hx),
        .hp_y(hy), .hp_z(hz), .orient(orient), .orient_change(orient_change),
        .motion_flag(motion_flag), .motion_start(motion_start), .motion_end(motion_end));

    // Counts one comparison and reports a difference at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Model of one sample set: candidate, debounce, then motion qualification.
    task automatic step(input int x, input int y, input int z, input int px, input int py,
                        input int pz);
        int c;
        int raw;
        c = cur;
        if (x * x + y * y <= 144) c = (z < 0) ? 1 : 0;
        else if (x >= 8 + h && y > h - 36 && y < 36 - h) c = 2;
        else if (x <= -8 - h && y > h - 36 && y < 36 - h) c = 3;
        else if (y >= 8 + h && x > h - 36 && x < 36 - h) c = 4;
        else if (y <= -8 - h && x > h - 36 && x < 36 - h) c = 5;
        chg = 0;
        st = 0;
        en = 0;
        if (c == cur) cnt = 0;
        else if (c == pend && cnt > 0) cnt++;
        else cnt = 1;
        pend = c;
        if (c != cur && cnt >= tt) begin
            cur = c;
            cnt = 0;
            chg = 1;
        end
        raw = (px > 8 || px < -8 || py > 8 || py < -8 || pz > 8 || pz < -8);
        mcnt = (raw != act) ? mcnt + 1 : 0;
        if (mcnt > 0 && mcnt >= ((wt > 1) ? wt : 1)) begin
            act = raw;
            mcnt = 0;
            st = raw;
            en = !raw && !lat;
            stk = stk | raw;
        end
    endtask : step

    // Hangs are cut short well past the expected run length.
    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    // Reset values first, then three configurations of random sample sets.
    initial begin
        void'($urandom(32'hE9C9));
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        foreach (ra[k]) begin
            i_host.acc(1'b0, ra[k], 8'h00);
            chk(reg_rdata, rv[k], "reset value");
        end
        for (int p = 0; p < 3; p++) begin
            h = 20 - 6 * p;
            lat = p % 2;
            tt = $urandom_range(0, 3);
            wt = $urandom_range(0, 3);
            i_host.cfg(5'(h), 8'(tt), 8'(wt), (lat != 0) ? 8'h90 : 8'h80);
            cnt = 0;
            mcnt = 0;
            stk = 0;
            i_host.acc(1'b0, `OMDET_ADDR_HYST, 8'h00);
            chk(reg_rdata, 8'(h), "hysteresis readback");
            for (int j = 0; j < 250; j++) begin
                if ($urandom_range(0, 2) == 0) begin
                    ax = 8'($urandom_range(0, 64) - 32);
                    ay = 8'($urandom_range(0, 64) - 32);
                    az = 8'($urandom_range(0, 64) - 32);
                end
                if ($urandom_range(0, 2) == 0) begin
                    hx = 8'($urandom_range(0, 40) - 20);
                    hy = 8'($urandom_range(0, 40) - 20);
                    hz = 8'($urandom_range(0, 40) - 20);
                end
                if (lat != 0 && j % 60 == 30) begin
                    i_host.acc(1'b1, `OMDET_ADDR_MOTION_CLR, 8'h01);
                    stk = 0;
                end
                @(negedge clk);
                sample_valid = 1'b1;
                step(ax, ay, az, hx, hy, hz);
                @(negedge clk);
                sample_valid = 1'b0;
                chk({5'h00, orient}, 8'(cur), "orientation");
                chk({7'h00, orient_change}, 8'(chg), "change pulse");
                chk({7'h00, motion_start}, 8'(st), "motion start");
                chk({7'h00, motion_end}, 8'(en), "motion end");
                chk({7'h00, motion_flag}, 8'((lat != 0) ? stk : act), "flag");
            end
        end
        // Samples taken while detection is off must leave every output alone.
        i_host.acc(1'b1, `OMDET_ADDR_CTRL1, 8'h00);
        ax = (cur == 2) ? 8'hE2 : 8'h1E;
        ay = 8'h00;
        hx = (act != 0) ? 8'h00 : 8'h14;
        hy = 8'h00;
        hz = 8'h00;
        repeat (4) begin
            @(negedge clk);
            sample_valid = 1'b1;
            @(negedge clk);
            sample_valid = 1'b0;
            chk({5'h00, orient}, 8'(cur), "orientation while off");
            chk({7'h00, orient_change}, 8'h00, "change pulse while off");
            chk({7'h00, motion_start | motion_end}, 8'h00, "motion pulse while off");
        end
        i_host.acc(1'b0, `OMDET_ADDR_STATUS, 8'h00);
        chk(reg_rdata, {4'h0, 1'((lat != 0) ? stk : act), 3'(cur)}, "status");
        // A reset in mid-run must restore the defaults without waiting for a clock.
        @(negedge clk);
        nrst = 1'b0;
        #1;
        chk({4'h0, motion_flag, orient}, 8'h00, "state in reset");
        chk(reg_rdata, 8'h00, "read data in reset");
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        i_host.acc(1'b0, `OMDET_ADDR_HYST, 8'h00);
        chk(reg_rdata, `OMDET_RST_HYST, "hysteresis after reset");
        wrap_up();
    end
endmodule : testbench
